// ---- rtl/hpbi_top.sv ----
// host processor bus interface: arbitration, request capture, data
// phase signalling, processor reset and coprocessor error sideband
// assumes open-drain pins resolved outside; inputs synchronous to clk_i
// Operation
// - mask address bit 20 when the gate input or legacy control bit is set.
// - bus owner strobes the first of two request phase cycles.
// - block-next-request stops the request owner issuing further requests.
// - device, the only priority agent, requests priority to own the bus.
// - symmetric request held in processor reset, released two clocks after.
// - processor reset formed from peripheral reset and suspend status.
// - data bus owner holds busy through transfers longer than one cycle.
// - defer line signals a deferred response chosen by the defer policy.
// - defer line also signals a retry response.
// - data source asserts data ready in each cycle data moves.
// - numeric error raises interrupt line thirteen internally.
// - ignore-numeric-error driven only while numeric error is active.
// - enabled error write during numeric error sets ignore until it ends.
// - host address lines are inputs during processor cycles.
// - host address lines are inverted on the bus.
// - host data lines are inverted on reads and writes.
// - hash-named signals are active low, others active high.
// - no snoopable peripheral access to memory while locked.
`timescale 1ns/1ps
`include "hpbi_defs.svh"
module hpbi_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  // sideband
  input wire logic gate_addr_bit20_input_i,
  input wire logic legacy_a20_bit_i,
  output logic addr_bit20_mask_out_oe_o,
  input wire logic numeric_error_in_n_i,
  input wire logic cp_err_enable_i,
  input wire logic cp_err_write_i,
  output logic ignore_numeric_error_out_oe_o,
  output logic coprocessor_interrupt_line_o,
  input wire logic peripheral_bus_reset_n_i,
  input wire logic suspend_status_in_n_i,
  output logic processor_reset_out_oe_o,
  output logic symmetric_bus_request_oe_o,
  // pins
  input wire logic request_strobe_n_i,
  output logic request_strobe_oe_o,
  input wire logic block_next_request_n_i,
  input wire logic priority_bus_request_n_i,
  output logic priority_bus_request_oe_o,
  input wire logic bus_lock_n_i,
  input wire logic [`HPBI_CMD_W-1:0] request_cmd_n_i,
  input wire logic [`HPBI_ADDR_W-1:0] host_address_lines_n_i,
  output logic [`HPBI_ADDR_W-1:0] host_address_lines_n_o,
  output logic host_address_lines_oe_o,
  input wire logic [`HPBI_DATA_W-1:0] host_data_lines_n_i,
  output logic [`HPBI_DATA_W-1:0] host_data_lines_n_o,
  output logic host_data_lines_oe_o,
  input wire logic data_bus_busy_flag_n_i,
  output logic data_bus_busy_flag_oe_o,
  input wire logic data_valid_strobe_n_i,
  output logic data_valid_strobe_oe_o,
  output logic defer_oe_o,
  // core side
  input wire logic own_need_bus_i,
  input wire logic [`HPBI_ADDR_W-1:0] own_addr_i,
  output logic own_done_o,
  output logic req_valid_o,
  output logic [`HPBI_ADDR_W-1:0] req_addr_o,
  output logic [`HPBI_CMD_W-1:0] req_cmd_o,
  output logic snoop_block_o,
  input wire logic defer_req_i,
  input wire logic retry_req_i,
  input wire logic rd_valid_i,
  input wire logic rd_last_i,
  input wire logic [`HPBI_DATA_W-1:0] rd_data_i,
  output logic wr_valid_o,
  output logic [`HPBI_DATA_W-1:0] wr_data_o
);
  function automatic logic [`HPBI_ADDR_W-1:0] addr_flip(
    input logic [`HPBI_ADDR_W-1:0] v);
    addr_flip = ~v;
  endfunction

  function automatic logic [`HPBI_DATA_W-1:0] data_flip(
    input logic [`HPBI_DATA_W-1:0] v);
    data_flip = ~v;
  endfunction

  // active-high views of low-true pins
  logic nerr_act, lock_act, block_act, strobe_act, valid_act;
  assign nerr_act = !numeric_error_in_n_i;
  assign lock_act = !bus_lock_n_i;
  assign block_act = !block_next_request_n_i;
  assign strobe_act = !request_strobe_n_i;
  assign valid_act = !data_valid_strobe_n_i;

  hpbi_rstgen u_rstgen (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .peripheral_bus_reset_n_i(peripheral_bus_reset_n_i),
    .suspend_status_in_n_i(suspend_status_in_n_i),
    .processor_reset_out_oe_o(processor_reset_out_oe_o),
    .symmetric_bus_request_oe_o(symmetric_bus_request_oe_o)
  );

  // sideband
  logic a20_q, a20_d, ign_q, ign_d, irq_q, irq_d;
  always_comb begin
    a20_d = gate_addr_bit20_input_i || legacy_a20_bit_i;
    irq_d = nerr_act;
    // clear only when error ends, so set and clear never collide
    ign_d = nerr_act &&
      (ign_q || (cp_err_write_i && cp_err_enable_i));
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a20_q <= 1'b0;
      ign_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      a20_q <= a20_d;
      ign_q <= ign_d;
      irq_q <= irq_d;
    end
  end

  assign addr_bit20_mask_out_oe_o = a20_q;
  assign ignore_numeric_error_out_oe_o = ign_q;
  assign coprocessor_interrupt_line_o = irq_q;

  // priority arbitration and own request phase
  hpbi_pkg::hpbi_arb_st_t st_q, st_d;
  logic [`HPBI_ADDR_W-1:0] oaddr_q, oaddr_d;
  logic done_q, done_d, pri_q, pri_d, stb_q, stb_d;
  always_comb begin
    st_d = st_q;
    oaddr_d = oaddr_q;
    done_d = 1'b0;
    case (st_q)
      hpbi_pkg::HPBI_ST_IDLE: begin
        if (own_need_bus_i && !processor_reset_out_oe_o) begin
          st_d = hpbi_pkg::HPBI_ST_REQ;
          oaddr_d = addr_flip(own_addr_i);
        end
      end
      hpbi_pkg::HPBI_ST_REQ: begin
        // a locked sequence keeps the processor on the bus
        if (!block_act && !lock_act && !strobe_act) begin
          st_d = hpbi_pkg::HPBI_ST_STB;
        end
      end
      hpbi_pkg::HPBI_ST_STB: begin
        st_d = hpbi_pkg::HPBI_ST_PH2;
      end
      hpbi_pkg::HPBI_ST_PH2: begin
        st_d = hpbi_pkg::HPBI_ST_IDLE;
        done_d = 1'b1;
      end
      default: begin
        st_d = hpbi_pkg::HPBI_ST_IDLE;
      end
    endcase
    pri_d = (st_d != hpbi_pkg::HPBI_ST_IDLE);
    stb_d = (st_d == hpbi_pkg::HPBI_ST_STB);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= hpbi_pkg::HPBI_ST_IDLE;
      oaddr_q <= '0;
      done_q <= 1'b0;
      pri_q <= 1'b0;
      stb_q <= 1'b0;
    end else begin
      st_q <= st_d;
      oaddr_q <= oaddr_d;
      done_q <= done_d;
      pri_q <= pri_d;
      stb_q <= stb_d;
    end
  end

  assign own_done_o = done_q;
  assign priority_bus_request_oe_o = pri_q;
  assign request_strobe_oe_o = stb_q;
  assign host_address_lines_oe_o = st_q[1];
  assign host_address_lines_n_o = oaddr_q;

  // capture of processor requests
  logic rv_q, rv_d, sb_q, sb_d;
  logic [`HPBI_ADDR_W-1:0] ra_q, ra_d;
  logic [`HPBI_CMD_W-1:0] rc_q, rc_d;
  always_comb begin
    rv_d = strobe_act && !request_strobe_oe_o;
    ra_d = rv_d ? addr_flip(host_address_lines_n_i) : ra_q;
    rc_d = rv_d ? ~request_cmd_n_i : rc_q;
    // held from a locked strobe until the lock drops
    sb_d = lock_act && (sb_q || rv_d);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rv_q <= 1'b0;
      ra_q <= '0;
      rc_q <= '0;
      sb_q <= 1'b0;
    end else begin
      rv_q <= rv_d;
      ra_q <= ra_d;
      rc_q <= rc_d;
      sb_q <= sb_d;
    end
  end

  assign req_valid_o = rv_q;
  assign req_addr_o = ra_q;
  assign req_cmd_o = rc_q;
  assign snoop_block_o = sb_q;

  // data phase and response
  logic drv_q, drv_d, bsy_q, bsy_d, def_q, def_d, wv_q, wv_d;
  logic [`HPBI_DATA_W-1:0] do_q, do_d, wd_q, wd_d;
  always_comb begin
    drv_d = rd_valid_i;
    do_d = rd_valid_i ? data_flip(rd_data_i) : do_q;
    // busy stays up across gaps until the last beat is sent
    bsy_d = rd_valid_i ? !rd_last_i : (bsy_q && !rd_last_i);
    def_d = defer_req_i || retry_req_i;
    wv_d = valid_act && !data_valid_strobe_oe_o;
    wd_d = wv_d ? data_flip(host_data_lines_n_i) : wd_q;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drv_q <= 1'b0;
      do_q <= '0;
      bsy_q <= 1'b0;
      def_q <= 1'b0;
      wv_q <= 1'b0;
      wd_q <= '0;
    end else begin
      drv_q <= drv_d;
      do_q <= do_d;
      bsy_q <= bsy_d;
      def_q <= def_d;
      wv_q <= wv_d;
      wd_q <= wd_d;
    end
  end

  assign data_valid_strobe_oe_o = drv_q;
  assign host_data_lines_oe_o = drv_q;
  assign host_data_lines_n_o = do_q;
  assign data_bus_busy_flag_oe_o = bsy_q;
  assign defer_oe_o = def_q;
  assign wr_valid_o = wv_q;
  assign wr_data_o = wd_q;

  a_a20_or: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (gate_addr_bit20_input_i || legacy_a20_bit_i) |=> a20_q)
    else $error("address bit 20 mask not raised");
  a_stb_phase: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(request_strobe_oe_o) |-> host_address_lines_oe_o ##1
    (!request_strobe_oe_o && host_address_lines_oe_o))
    else $error("own request phase not two cycles");
  a_stb_block: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(request_strobe_oe_o) |-> !$past(block_act) && !$past(lock_act))
    else $error("request issued while blocked or locked");
  a_prio_own: assert property (@(posedge clk_i) disable iff (!resetn_i)
    host_address_lines_oe_o |-> priority_bus_request_oe_o)
    else $error("address driven without priority request");
  a_ign_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ign_q |-> $past(nerr_act))
    else $error("ignore error without numeric error");
  a_ign_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cp_err_write_i && cp_err_enable_i && nerr_act) ##1 nerr_act |-> ign_q)
    else $error("ignore error not set by write");
  a_irq_err: assert property (@(posedge clk_i) disable iff (!resetn_i)
    nerr_act |=> irq_q)
    else $error("interrupt thirteen not raised");
  a_req_cap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (strobe_act && !request_strobe_oe_o) |=>
    (rv_q && ra_q == ~$past(host_address_lines_n_i)))
    else $error("request address not captured inverted");
  a_rdy_data: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_valid_i |=> (drv_q && do_q == ~$past(rd_data_i)))
    else $error("data ready or data wrong");
  a_busy_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_valid_i && !rd_last_i) |=> bsy_q)
    else $error("data bus busy dropped mid transfer");
  a_defer_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (defer_req_i || retry_req_i) |=> def_q)
    else $error("defer not driven");
  a_lock_snp: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (strobe_act && lock_act && !request_strobe_oe_o) ##1 lock_act |-> sb_q)
    else $error("snoop not blocked under lock");
endmodule

// ---- rtl/hpbi_defs.svh ----
// constants of the host processor bus interface: widths and counts
// assumes inclusion by bare name from the design files
`ifndef HPBI_DEFS_SVH
`define HPBI_DEFS_SVH
`define HPBI_ADDR_W 29
`define HPBI_DATA_W 64
`define HPBI_CMD_W 5
`define HPBI_HOLD_W 2
`define HPBI_BREQ_HOLD 2'h2
`endif

// ---- rtl/hpbi_pkg.sv ----
// types of the host processor bus interface
// assumes nothing of its surroundings
package hpbi_pkg;
  typedef enum logic [1:0] {
    HPBI_ST_IDLE = 2'b00,
    HPBI_ST_REQ = 2'b01,
    HPBI_ST_STB = 2'b10,
    HPBI_ST_PH2 = 2'b11
  } hpbi_arb_st_t;
endpackage

// ---- rtl/hpbi_rstgen.sv ----
// processor reset and symmetric request strap generator
// assumes reset sources are synchronous to the host clock
`timescale 1ns/1ps
`include "hpbi_defs.svh"
module hpbi_rstgen (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic peripheral_bus_reset_n_i,
  input wire logic suspend_status_in_n_i,
  output logic processor_reset_out_oe_o,
  output logic symmetric_bus_request_oe_o
);
  logic rst_q, rst_d;
  logic breq_q, breq_d;
  logic [`HPBI_HOLD_W-1:0] cnt_q, cnt_d;

  always_comb begin
    rst_d = !peripheral_bus_reset_n_i || !suspend_status_in_n_i;
    if (rst_q) begin
      cnt_d = `HPBI_BREQ_HOLD;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 2'h1;
    end else begin
      cnt_d = cnt_q;
    end
    breq_d = rst_d || (cnt_d != '0);
  end

  // processor held in reset while the device itself is in reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q <= 1'b1;
      cnt_q <= `HPBI_BREQ_HOLD;
      breq_q <= 1'b1;
    end else begin
      rst_q <= rst_d;
      cnt_q <= cnt_d;
      breq_q <= breq_d;
    end
  end

  assign processor_reset_out_oe_o = rst_q;
  assign symmetric_bus_request_oe_o = breq_q;

  a_sym_drop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(rst_q) |-> breq_q ##1 breq_q ##1 !breq_q)
    else $error("symmetric request not released two clocks after reset");
  a_prst_src: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!peripheral_bus_reset_n_i || !suspend_status_in_n_i) |=> rst_q)
    else $error("processor reset not asserted by its sources");
endmodule

// ---- testbench/hpbi_cpu_model.sv ----
// processor model on the far side of the host bus interface
// assumes the bench resolves open-drain pins; tasks start at a clock edge
`timescale 1ns/1ps
`include "hpbi_defs.svh"
module hpbi_cpu_model (
  input wire logic clk_i,
  input wire logic prio_pin_i,
  output logic strobe_n_o,
  output logic lock_n_o,
  output logic [`HPBI_CMD_W-1:0] cmd_n_o,
  output logic [`HPBI_ADDR_W-1:0] addr_n_o,
  output logic addr_oe_o,
  output logic [`HPBI_DATA_W-1:0] data_n_o,
  output logic data_oe_o,
  output logic valid_n_o
);
  initial begin
    {strobe_n_o, lock_n_o, valid_n_o, addr_oe_o, data_oe_o} = 5'h1C;
    cmd_n_o = '1;
    addr_n_o = '1;
    data_n_o = '1;
  end
  task automatic issue(input logic [`HPBI_ADDR_W-1:0] a,
      input logic [`HPBI_CMD_W-1:0] c, input logic lk);
    int n;
    n = 0;
    // a held lock lets the atomic sequence go on past a priority request
    while (!prio_pin_i && lock_n_o && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    #1 strobe_n_o = 1'h0;
    lock_n_o = ~lk;
    cmd_n_o = ~c;
    addr_n_o = ~a;
    addr_oe_o = 1'h1;
    @(posedge clk_i);
    #1 strobe_n_o = 1'h1;
    @(posedge clk_i);
    #1 addr_oe_o = 1'h0;
    cmd_n_o = '1;
  endtask
  task automatic unlock();
    #1 lock_n_o = 1'h1;
  endtask
  task automatic write(input logic [`HPBI_DATA_W-1:0] d);
    #1 valid_n_o = 1'h0;
    data_n_o = ~d;
    data_oe_o = 1'h1;
    @(posedge clk_i);
    #1 valid_n_o = 1'h1;
    data_oe_o = 1'h0;
  endtask
endmodule

// ---- testbench/test_hpbi_top.sv ----
// self-checking bench of the host processor bus interface
// assumes released bus pins float high through their pull-ups
`timescale 1ns/1ps
`include "hpbi_defs.svh"
module test_hpbi_top;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic gate = 0, legacy = 0, err_n = 1, cpe = 0, cpw = 0, brst_n = 0;
  logic sus_n = 0, block_n = 1, need = 0, dfr = 0, rty = 0, rdv = 0, rdl = 0;
  logic [`HPBI_ADDR_W-1:0] own_a = '0;
  logic [`HPBI_DATA_W-1:0] rdd = '0;
  logic c_stb_n, c_lock_n, c_aoe, c_doe, c_dv_n;
  logic [`HPBI_CMD_W-1:0] c_cmd_n, rqc;
  logic [`HPBI_ADDR_W-1:0] c_addr_n, a_no, rqa;
  logic [`HPBI_DATA_W-1:0] c_data_n, d_no, wrd;
  logic mask_oe, ign_oe, irq, rst_oe, sym_oe, stb_oe, pri_oe, a_oe, d_oe;
  logic bsy_oe, dv_oe, dfr_oe, done, rqv, snb, wrv;
  int mismatches = 0;
  int n_compared = 0;
  wire logic stb_pin = ~stb_oe & c_stb_n;
  wire logic pri_pin = ~pri_oe;
  wire logic dv_pin = ~dv_oe & c_dv_n;
  wire logic [`HPBI_ADDR_W-1:0] a_pin = a_oe ? a_no : (c_aoe ? c_addr_n : '1);
  wire logic [`HPBI_DATA_W-1:0] d_pin = d_oe ? d_no : (c_doe ? c_data_n : '1);
  always #2.5 clk_i = ~clk_i;
  hpbi_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .gate_addr_bit20_input_i(gate), .legacy_a20_bit_i(legacy),
    .addr_bit20_mask_out_oe_o(mask_oe), .numeric_error_in_n_i(err_n),
    .cp_err_enable_i(cpe), .cp_err_write_i(cpw),
    .ignore_numeric_error_out_oe_o(ign_oe), .coprocessor_interrupt_line_o(irq),
    .peripheral_bus_reset_n_i(brst_n), .suspend_status_in_n_i(sus_n),
    .processor_reset_out_oe_o(rst_oe), .symmetric_bus_request_oe_o(sym_oe),
    .request_strobe_n_i(stb_pin), .request_strobe_oe_o(stb_oe),
    .block_next_request_n_i(block_n), .priority_bus_request_n_i(pri_pin),
    .priority_bus_request_oe_o(pri_oe), .bus_lock_n_i(c_lock_n),
    .request_cmd_n_i(c_cmd_n), .host_address_lines_n_i(a_pin),
    .host_address_lines_n_o(a_no), .host_address_lines_oe_o(a_oe),
    .host_data_lines_n_i(d_pin), .host_data_lines_n_o(d_no),
    .host_data_lines_oe_o(d_oe), .data_bus_busy_flag_n_i(~bsy_oe),
    .data_bus_busy_flag_oe_o(bsy_oe), .data_valid_strobe_n_i(dv_pin),
    .data_valid_strobe_oe_o(dv_oe), .defer_oe_o(dfr_oe),
    .own_need_bus_i(need), .own_addr_i(own_a), .own_done_o(done),
    .req_valid_o(rqv), .req_addr_o(rqa), .req_cmd_o(rqc),
    .snoop_block_o(snb), .defer_req_i(dfr), .retry_req_i(rty),
    .rd_valid_i(rdv), .rd_last_i(rdl), .rd_data_i(rdd), .wr_valid_o(wrv),
    .wr_data_o(wrd));
  hpbi_cpu_model u_cpu (.clk_i(clk_i), .prio_pin_i(pri_pin),
    .strobe_n_o(c_stb_n), .lock_n_o(c_lock_n), .cmd_n_o(c_cmd_n),
    .addr_n_o(c_addr_n), .addr_oe_o(c_aoe), .data_n_o(c_data_n),
    .data_oe_o(c_doe), .valid_n_o(c_dv_n));
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic t_reset();
    chk("rst", rst_oe, 1'h1);
    chk("sym", sym_oe, 1'h1);
    resetn_i = 1'h1;
    brst_n = 1'h1;
    step(2);
    chk("rst susp", rst_oe, 1'h1);
    sus_n = 1'h1;
    step();
    chk("rst off", rst_oe, 1'h0);
    step();
    chk("sym held", sym_oe, 1'h1);
    step();
    chk("sym off", sym_oe, 1'h0);
    $display("reset test done");
  endtask
  task automatic t_mask();
    for (int i = 0; i < 4; i++) begin
      {gate, legacy} = i[1:0];
      step();
      chk("mask", mask_oe, i != 0);
    end
    $display("mask test done");
  endtask
  task automatic t_err();
    {err_n, cpw} = 2'h1;
    step();
    cpw = 1'h0;
    chk("irq", irq, 1'h1);
    chk("ign no enable", ign_oe, 1'h0);
    {err_n, cpe, cpw} = 3'h7;
    step();
    chk("ign no error", ign_oe, 1'h0);
    err_n = 1'h0;
    step();
    cpw = 1'h0;
    chk("ign set", ign_oe, 1'h1);
    step(3);
    chk("ign held", ign_oe, 1'h1);
    err_n = 1'h1;
    step();
    chk("ign clear", ign_oe, 1'h0);
    chk("irq clear", irq, 1'h0);
    $display("error test done");
  endtask
  task automatic t_own();
    {block_n, need} = 2'h1;
    own_a = 29'h1ABC_DEF5;
    step();
    need = 1'h0;
    chk("prio", pri_oe, 1'h1);
    step(3);
    chk("blocked", stb_oe, 1'h0);
    block_n = 1'h1;
    step();
    chk("strobe", stb_oe, 1'h1);
    chk("addr pins", a_pin, {~own_a});
    step();
    chk("strobe 2nd", stb_oe, 1'h0);
    chk("addr 2nd", a_oe, 1'h1);
    step();
    chk("done", done, 1'h1);
    $display("own request test done");
  endtask
  task automatic t_cap();
    for (int i = 0; i < 2; i++) begin
      fork
        u_cpu.issue(29'h0F0F_0F0F ^ i, 5'h15 - i, i);
        begin
          step();
          chk("req valid", rqv, 1'h1);
          chk("req addr", rqa, 29'h0F0F_0F0F ^ i);
          chk("req cmd", rqc, 5'h15 - i);
          step();
          chk("snoop", snb, i);
        end
      join
    end
    u_cpu.unlock();
    step();
    chk("snoop off", snb, 1'h0);
    $display("capture test done");
  endtask
  task automatic t_data();
    {rdv, rdd} = {1'h1, 64'h0123_4567_89AB_CDEF};
    step();
    {rdl, rdd} = {1'h1, 64'hFEDC_BA98_7654_3210};
    chk("rd pins", d_pin, ~64'h0123_4567_89AB_CDEF);
    chk("ready", dv_oe, 1'h1);
    chk("busy", bsy_oe, 1'h1);
    step();
    {rdv, rdl} = 2'h0;
    chk("rd pins 2", d_pin, ~64'hFEDC_BA98_7654_3210);
    step();
    chk("ready off", dv_oe, 1'h0);
    u_cpu.write(64'h5A5A_0000_FFFF_A5A5);
    chk("wr valid", wrv, 1'h1);
    chk("wr data", wrd, 64'h5A5A_0000_FFFF_A5A5);
    $display("data test done");
  endtask
  task automatic t_resp();
    for (int i = 0; i < 2; i++) begin
      {dfr, rty} = i ? 2'h1 : 2'h2;
      step();
      {dfr, rty} = 2'h0;
      chk("defer", dfr_oe, 1'h1);
      step();
      chk("defer off", dfr_oe, 1'h0);
    end
    $display("response test done");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #1;
    t_reset();
    t_mask();
    t_err();
    t_own();
    t_cap();
    t_data();
    t_resp();
    tally_and_finish();
  end
  // whole sequence needs well under a thousand cycles
  initial begin
    #5000;
    mismatches++;
    tally_and_finish();
  end
endmodule
